// ### design/msrs_pkg.sv
// package: register map, field layout, carriers and state of the magnetic sample readout block
package msrs_pkg;

   // ==========================================================
   // register offsets
   localparam logic [7:0] ADDR_STATUS = 8'h32;
   localparam logic [7:0] ADDR_MAG_X_HI = 8'h33;
   localparam logic [7:0] ADDR_MAG_X_LO = 8'h34;
   localparam logic [7:0] ADDR_MAG_Y_HI = 8'h35;
   localparam logic [7:0] ADDR_MAG_Y_LO = 8'h36;
   localparam logic [7:0] ADDR_MAG_Z_HI = 8'h37;
   localparam logic [7:0] ADDR_MAG_Z_LO = 8'h38;
   localparam logic [7:0] ADDR_ACC_X_HI = 8'h39;
   localparam logic [7:0] ADDR_ACC_X_LO = 8'h3a;
   localparam logic [7:0] ADDR_ACC_Y_HI = 8'h3b;
   localparam logic [7:0] ADDR_ACC_Y_LO = 8'h3c;
   localparam logic [7:0] ADDR_ACC_Z_HI = 8'h3d;
   localparam logic [7:0] ADDR_ACC_Z_LO = 8'h3e;
   localparam logic [2:0][7:0] MAG_HI_ADDR = {ADDR_MAG_Z_HI, ADDR_MAG_Y_HI, ADDR_MAG_X_HI};
   localparam logic [7:0] UNMAPPED_DATA = 8'h00;

   // ==========================================================
   // widths and field positions
   localparam int AXES = 3;
   localparam int MAG_W = 16;
   localparam int ACC_W = 14;
   localparam int ACC_SUM_W = 21;
   localparam int FIFO_DEPTH = 8;
   localparam int ST_ALL_OW = 7;
   localparam int ST_OW_LSB = 4;
   localparam int ST_ALL_DR = 3;
   localparam int ST_DR_LSB = 0;
   localparam logic [2:0] ALL_AXES = 3'h7;
   localparam logic [1:0] ACC_HI_PAD = 2'h0;

   // ==========================================================
   // reset values
   localparam logic [7:0] STATUS_RST = 8'h00;

   // ==========================================================
   // carriers
   typedef struct packed {
      logic [AXES-1:0] axis_done;
      logic [AXES-1:0][MAG_W-1:0] mag;
   } msrs_mag_sample_t;

   typedef struct packed {
      logic [AXES-1:0][ACC_W-1:0] acc;
   } msrs_accel_sample_t;

   typedef struct packed {
      logic en;
      logic [7:0] addr;
   } msrs_rd_req_t;

   typedef struct packed {
      logic valid;
      logic [7:0] data;
   } msrs_rd_rsp_t;

   localparam int MAG_SAMPLE_W = $bits(msrs_mag_sample_t);

   // ==========================================================
   // block state
   typedef struct packed {
      logic [7:0] status;
      logic [AXES-1:0][MAG_W-1:0] mag;
      logic [AXES-1:0][ACC_W-1:0] aligned;
      logic [AXES-1:0][ACC_W-1:0] acc_hold;
      logic [AXES-1:0][ACC_SUM_W-1:0] acc_sum;
      logic [7:0] win_cnt;
      logic [AXES-1:0] pend;
      logic [AXES-1:0] rd_seen;
      logic shadow_vld;
      logic [7:0] shadow_addr;
      logic [7:0] shadow_data;
      msrs_rd_rsp_t rsp;
   } msrs_state_t;

endpackage

// ### design/msrs_top.sv
// magnetic sample readout: sample fifo, status flags, output registers and aligned acceleration
`timescale 1ns/10ps

// ==========================================================
// sample fifo
module msrs_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic in_valid_i,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic in_ready_o,
   output logic out_valid_o,
   output logic [WIDTH-1:0] out_data_o,
   input wire logic out_ready_i
);
   localparam int AW = $clog2(DEPTH);
   localparam int CW = AW + 1;

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0] wr;
      logic [AW-1:0] rd;
      logic [CW-1:0] cnt;
      logic in_rdy;
   } msrs_fifo_state_t;

   msrs_fifo_state_t st_ff;
   msrs_fifo_state_t nxt_st;
   logic push;
   logic pop;

   always_comb begin
      nxt_st = st_ff;
      push = in_valid_i & st_ff.in_rdy;
      pop = out_ready_i & (st_ff.cnt != '0);
      if (push) begin
         nxt_st.mem[st_ff.wr] = in_data_i;
         nxt_st.wr = st_ff.wr + AW'(1);
      end
      if (pop) begin
         nxt_st.rd = st_ff.rd + AW'(1);
      end
      nxt_st.cnt = st_ff.cnt + CW'(push) - CW'(pop);
      nxt_st.in_rdy = (nxt_st.cnt != CW'(DEPTH));
   end

   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign in_ready_o = st_ff.in_rdy;
   assign out_valid_o = (st_ff.cnt != '0);
   assign out_data_o = st_ff.mem[st_ff.rd];
endmodule

// ==========================================================
// readout top
module msrs_top (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic sample_valid_i,
   input wire msrs_pkg::msrs_mag_sample_t sample_i,
   output logic sample_ready_o,
   input wire logic accel_valid_i,
   input wire msrs_pkg::msrs_accel_sample_t accel_i,
   input wire logic meas_cycle_end_i,
   input wire logic [2:0] output_rate_select_i,
   input wire logic [2:0] mag_oversample_ratio_i,
   input wire msrs_pkg::msrs_rd_req_t rd_req_i,
   output msrs_pkg::msrs_rd_rsp_t rd_rsp_o
);
   msrs_pkg::msrs_state_t st_ff;
   msrs_pkg::msrs_state_t nxt_st;
   msrs_pkg::msrs_mag_sample_t fifo_out;
   logic fifo_valid;
   logic commit;
   logic overwrite;
   logic [2:0] clr;
   logic [2:0] shift;
   logic [7:0] win_nxt;
   logic [msrs_pkg::AXES-1:0][msrs_pkg::ACC_SUM_W-1:0] sum_new;

   // ==========================================================
   // helpers
   function automatic logic [2:0] dec_shift(input logic [2:0] rate, input logic [2:0] osr);
      dec_shift = (osr > rate) ? (osr - rate) : 3'h0;
   endfunction

   function automatic logic is_high(input logic [7:0] a);
      is_high = (a >= msrs_pkg::ADDR_MAG_X_HI) && (a <= msrs_pkg::ADDR_ACC_Z_HI) && a[0];
   endfunction

   function automatic logic [7:0] reg_byte(input msrs_pkg::msrs_state_t s, input logic [7:0] a);
      case (a)
         msrs_pkg::ADDR_STATUS: reg_byte = s.status;
         msrs_pkg::ADDR_MAG_X_HI: reg_byte = s.mag[0][15:8];
         msrs_pkg::ADDR_MAG_X_LO: reg_byte = s.mag[0][7:0];
         msrs_pkg::ADDR_MAG_Y_HI: reg_byte = s.mag[1][15:8];
         msrs_pkg::ADDR_MAG_Y_LO: reg_byte = s.mag[1][7:0];
         msrs_pkg::ADDR_MAG_Z_HI: reg_byte = s.mag[2][15:8];
         msrs_pkg::ADDR_MAG_Z_LO: reg_byte = s.mag[2][7:0];
         msrs_pkg::ADDR_ACC_X_HI: reg_byte = {msrs_pkg::ACC_HI_PAD, s.aligned[0][13:8]};
         msrs_pkg::ADDR_ACC_X_LO: reg_byte = s.aligned[0][7:0];
         msrs_pkg::ADDR_ACC_Y_HI: reg_byte = {msrs_pkg::ACC_HI_PAD, s.aligned[1][13:8]};
         msrs_pkg::ADDR_ACC_Y_LO: reg_byte = s.aligned[1][7:0];
         msrs_pkg::ADDR_ACC_Z_HI: reg_byte = {msrs_pkg::ACC_HI_PAD, s.aligned[2][13:8]};
         msrs_pkg::ADDR_ACC_Z_LO: reg_byte = s.aligned[2][7:0];
         default: reg_byte = msrs_pkg::UNMAPPED_DATA;
      endcase
   endfunction

   // ==========================================================
   // sample fifo, drained once per measurement cycle
   msrs_fifo #(
      .WIDTH(msrs_pkg::MAG_SAMPLE_W),
      .DEPTH(msrs_pkg::FIFO_DEPTH)
   ) u_fifo (
      .clk_i(clk_i),
      .rst_b_i(rst_b_i),
      .in_valid_i(sample_valid_i),
      .in_data_i(sample_i),
      .in_ready_o(sample_ready_o),
      .out_valid_o(fifo_valid),
      .out_data_o(fifo_out),
      .out_ready_i(meas_cycle_end_i)
   );

   // ==========================================================
   // next state
   always_comb begin
      nxt_st = st_ff;
      commit = meas_cycle_end_i & fifo_valid;
      overwrite = 1'b0;
      clr = 3'h0;
      shift = dec_shift(output_rate_select_i, mag_oversample_ratio_i);
      win_nxt = st_ff.win_cnt + 8'h01;
      sum_new = '0;

      // register reads, one-cycle answer
      nxt_st.rsp.valid = rd_req_i.en;
      if (rd_req_i.en) begin
         if (st_ff.shadow_vld && (rd_req_i.addr == st_ff.shadow_addr)) begin
            nxt_st.rsp.data = st_ff.shadow_data;
         end else begin
            nxt_st.rsp.data = reg_byte(st_ff, rd_req_i.addr);
         end
         nxt_st.shadow_vld = 1'b0;
         if (is_high(rd_req_i.addr)) begin
            // low byte frozen so the pair stays one sample
            nxt_st.shadow_vld = 1'b1;
            nxt_st.shadow_addr = rd_req_i.addr + 8'h01;
            nxt_st.shadow_data = reg_byte(st_ff, rd_req_i.addr + 8'h01);
         end
         for (int i = 0; i < msrs_pkg::AXES; i++) begin
            clr[i] = (rd_req_i.addr == msrs_pkg::MAG_HI_ADDR[i]);
         end
      end

      // clears first, so a set in the same cycle wins
      for (int i = 0; i < msrs_pkg::AXES; i++) begin
         if (clr[i]) begin
            nxt_st.status[msrs_pkg::ST_DR_LSB+i] = 1'b0;
            nxt_st.status[msrs_pkg::ST_OW_LSB+i] = 1'b0;
         end
      end
      nxt_st.rd_seen = st_ff.rd_seen | clr;
      if (nxt_st.rd_seen == msrs_pkg::ALL_AXES) begin
         nxt_st.status[msrs_pkg::ST_ALL_DR] = 1'b0;
         nxt_st.status[msrs_pkg::ST_ALL_OW] = 1'b0;
         nxt_st.rd_seen = 3'h0;
      end

      // commit of one measurement cycle
      if (commit) begin
         for (int i = 0; i < msrs_pkg::AXES; i++) begin
            if (fifo_out.axis_done[i]) begin
               if (nxt_st.status[msrs_pkg::ST_DR_LSB+i]) begin
                  nxt_st.status[msrs_pkg::ST_OW_LSB+i] = 1'b1;
                  overwrite = 1'b1;
               end
               nxt_st.status[msrs_pkg::ST_DR_LSB+i] = 1'b1;
               nxt_st.mag[i] = fifo_out.mag[i];
            end
         end
         if (overwrite) begin
            nxt_st.status[msrs_pkg::ST_ALL_OW] = 1'b1;
         end
         nxt_st.pend = st_ff.pend | fifo_out.axis_done;
         if (nxt_st.pend == msrs_pkg::ALL_AXES) begin
            nxt_st.status[msrs_pkg::ST_ALL_DR] = 1'b1;
            nxt_st.pend = 3'h0;
         end
         nxt_st.aligned = st_ff.acc_hold;
      end

      // acceleration decimation
      if (accel_valid_i) begin
         for (int i = 0; i < msrs_pkg::AXES; i++) begin
            sum_new[i] = st_ff.acc_sum[i]
               + {{(msrs_pkg::ACC_SUM_W - msrs_pkg::ACC_W){accel_i.acc[i][13]}}, accel_i.acc[i]};
         end
         if (win_nxt >= (8'h01 << shift)) begin
            for (int i = 0; i < msrs_pkg::AXES; i++) begin
               nxt_st.acc_hold[i] = msrs_pkg::ACC_W'($signed(sum_new[i]) >>> shift);
            end
            nxt_st.acc_sum = '0;
            nxt_st.win_cnt = 8'h00;
         end else begin
            nxt_st.acc_sum = sum_new;
            nxt_st.win_cnt = win_nxt;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         st_ff <= '0;
         st_ff.status <= msrs_pkg::STATUS_RST;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign rd_rsp_o = st_ff.rsp;

   // ==========================================================
   // checks
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_b_i);

   a_xow_set: assert property (commit && fifo_out.axis_done[0] && st_ff.status[0] && !clr[0]
      |=> st_ff.status[4] && st_ff.status[7]) else $error("x overwrite not flagged");
   a_yow_set: assert property (commit && fifo_out.axis_done[1] && st_ff.status[1] && !clr[1]
      |=> st_ff.status[5]) else $error("y overwrite not flagged");
   a_zow_set: assert property (commit && fifo_out.axis_done[2] && st_ff.status[2] && !clr[2]
      |=> st_ff.status[6]) else $error("z overwrite not flagged");
   a_xdr_set: assert property (commit && fifo_out.axis_done[0]
      |=> st_ff.status[0] && (st_ff.mag[0] == $past(fifo_out.mag[0]))) else $error("x sample not committed");
   a_ydr_clear: assert property (rd_req_i.en && rd_req_i.addr == msrs_pkg::ADDR_MAG_Y_HI
      && !(commit && fifo_out.axis_done[1]) |=> !st_ff.status[1] && !st_ff.status[5]) else $error("y flags kept");
   a_zdr_clear: assert property (rd_req_i.en && rd_req_i.addr == msrs_pkg::ADDR_MAG_Z_HI
      && !(commit && fifo_out.axis_done[2]) |=> !st_ff.status[2]) else $error("z ready kept");
   a_all_clear: assert property ((st_ff.rd_seen | clr) == msrs_pkg::ALL_AXES && !commit
      |=> !st_ff.status[3] && !st_ff.status[7]) else $error("all-axes flags kept");
   a_all_ready: assert property (commit && ((st_ff.pend | fifo_out.axis_done) == msrs_pkg::ALL_AXES)
      |=> st_ff.status[3] && st_ff.pend == 3'h0) else $error("all-axes ready missing");
   a_accel_align: assert property (commit |=> st_ff.aligned == $past(st_ff.acc_hold))
      else $error("aligned accel not updated with sample");
   a_status_read: assert property (rd_req_i.en && rd_req_i.addr == msrs_pkg::ADDR_STATUS
      |=> rd_rsp_o.valid && rd_rsp_o.data == $past(st_ff.status)) else $error("status read wrong");
   a_accel_hi_pad: assert property (rd_req_i.en && rd_req_i.addr == msrs_pkg::ADDR_ACC_X_HI
      && !st_ff.shadow_vld |=> rd_rsp_o.data[7:6] == 2'h0) else $error("accel high byte not right justified");

   c_overwrite: cover property (commit && fifo_out.axis_done[0] && st_ff.status[0]);
   c_all_ready: cover property (st_ff.status[3] ##[1:20] !st_ff.status[3]);
   c_fifo_full: cover property (sample_valid_i && !sample_ready_o);
   c_pair_read: cover property (rd_req_i.en && is_high(rd_req_i.addr) ##1 rd_req_i.en && st_ff.shadow_vld);
endmodule

// ### test/msrs_host_model.sv
// host side model: issues single register reads on the read port and returns the answer
`timescale 1ns/10ps
module msrs_host_model (
   input wire logic clk_i,
   input wire logic go_i,
   input wire logic [7:0] addr_i,
   output msrs_pkg::msrs_rd_req_t rd_req_o,
   input wire msrs_pkg::msrs_rd_rsp_t rd_rsp_i,
   output logic done_o,
   output logic [7:0] data_o
);
   // ==========================================================
   // one request per go pulse; idle address shows a changing value
   initial begin
      rd_req_o = '0;
      done_o = 1'b0;
      data_o = 8'h00;
   end
   always @(posedge clk_i) begin
      rd_req_o.en <= go_i;
      rd_req_o.addr <= go_i ? addr_i : ~rd_req_o.addr;
      done_o <= rd_rsp_i.valid;
      if (rd_rsp_i.valid) begin
         data_o <= rd_rsp_i.data;
      end
   end
endmodule

// ### test/tb.sv
// testbench: drives samples and reads registers of the magnetic sample readout block
`timescale 1ns/10ps
module tb;
   logic clk_i, rst_b_i, sample_valid_i, accel_valid_i, meas_cycle_end_i, go, done, sample_ready_o;
   logic [2:0] output_rate_select_i, mag_oversample_ratio_i;
   logic [7:0] addr, rdata, data;
   msrs_pkg::msrs_mag_sample_t sample_i;
   msrs_pkg::msrs_accel_sample_t accel_i;
   msrs_pkg::msrs_rd_req_t rd_req;
   msrs_pkg::msrs_rd_rsp_t rd_rsp;
   int fails, total_checks, n, k;
   logic [7:0] row_addr [15];
   logic [7:0] row_exp [15];

   msrs_top dut_u (.clk_i(clk_i), .rst_b_i(rst_b_i), .sample_valid_i(sample_valid_i), .sample_i(sample_i),
      .sample_ready_o(sample_ready_o), .accel_valid_i(accel_valid_i), .accel_i(accel_i),
      .meas_cycle_end_i(meas_cycle_end_i), .output_rate_select_i(output_rate_select_i),
      .mag_oversample_ratio_i(mag_oversample_ratio_i), .rd_req_i(rd_req), .rd_rsp_o(rd_rsp));
   msrs_host_model host_u (.clk_i(clk_i), .go_i(go), .addr_i(addr), .rd_req_o(rd_req), .rd_rsp_i(rd_rsp),
      .done_o(done), .data_o(data));

   initial begin
      clk_i = 1'b0;
      forever #2 clk_i = ~clk_i;
   end

   // ==========================================================
   // tasks
   task stop_test;
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task chk(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task cyc(input int c);
      repeat (c) @(negedge clk_i);
   endtask
   task rdc(input logic [7:0] a, input logic [7:0] exp);
      int i;
      go = 1'b1;
      addr = a;
      cyc(1);
      go = 1'b0;
      for (i = 0; i < 8 && done !== 1'b1; i++) cyc(1);
      if (done !== 1'b1) begin
         fails++;
         stop_test;
      end
      rdata = data;
      chk(rdata, exp);
   endtask
   task put(input logic [2:0] ax, input logic [15:0] x, input logic [15:0] y, input logic [15:0] z);
      int i;
      sample_i.axis_done = ax;
      sample_i.mag = {z, y, x};
      sample_valid_i = 1'b1;
      for (i = 0; i < 20 && sample_ready_o !== 1'b1; i++) cyc(1);
      if (sample_ready_o !== 1'b1) begin
         fails++;
         stop_test;
      end
      cyc(1);
      sample_valid_i = 1'b0;
      meas_cycle_end_i = 1'b1;
      cyc(1);
      meas_cycle_end_i = 1'b0;
      cyc(1);
   endtask
   task acc(input logic [13:0] x, input logic [13:0] y, input logic [13:0] z);
      accel_i.acc = {z, y, x};
      accel_valid_i = 1'b1;
      cyc(1);
      accel_valid_i = 1'b0;
      cyc(1);
   endtask

   // ==========================================================
   // main sequence
   initial begin
      fails = 0;
      total_checks = 0;
      rst_b_i = 1'b0;
      {sample_valid_i, accel_valid_i, meas_cycle_end_i, go} = 4'h0;
      {output_rate_select_i, mag_oversample_ratio_i} = 6'h00;
      addr = 8'h00;
      sample_i = '0;
      accel_i = '0;
      row_addr = '{8'h32, 8'h33, 8'h34, 8'h35, 8'h36, 8'h37, 8'h38, 8'h32,
         8'h39, 8'h3a, 8'h3b, 8'h3c, 8'h3d, 8'h3e, 8'h32};
      row_exp = '{8'h0f, 8'h81, 8'h23, 8'h7f, 8'h45, 8'hfe, 8'h67, 8'h00,
         8'h2a, 8'hbc, 8'h12, 8'h34, 8'h3f, 8'h01, 8'h00};
      cyc(5);
      rst_b_i = 1'b1;
      rdc(8'h32, 8'h00);
      rdc(8'h40, 8'h00);
      acc(14'h2abc, 14'h1234, 14'h3f01);
      put(3'h7, 16'h8123, 16'h7f45, 16'hfe67);
      for (n = 0; n < 15; n++) rdc(row_addr[n], row_exp[n]);
      // unread data replaced on all axes, then cleared axis by axis
      put(3'h7, 16'h1111, 16'h2222, 16'h3333);
      put(3'h7, 16'h4444, 16'h5555, 16'h6666);
      rdc(8'h32, 8'hff);
      rdc(8'h33, 8'h44);
      rdc(8'h32, 8'hee);
      rdc(8'h37, 8'h66);
      rdc(8'h32, 8'haa);
      rdc(8'h35, 8'h55);
      rdc(8'h32, 8'h00);
      // single axes complete one at a time
      put(3'h1, 16'h0a0b, 16'h0000, 16'h0000);
      rdc(8'h32, 8'h01);
      put(3'h2, 16'h0000, 16'h0c0d, 16'h0000);
      rdc(8'h32, 8'h03);
      put(3'h4, 16'h0000, 16'h0000, 16'h0e0f);
      rdc(8'h32, 8'h0f);
      // low byte stays coherent across a commit between the two reads
      rdc(8'h33, 8'h0a);
      put(3'h7, 16'h5566, 16'h0c0d, 16'h0e0f);
      rdc(8'h34, 8'h0b);
      rdc(8'h33, 8'h55);
      rdc(8'h34, 8'h66);
      // x ready already cleared by the high byte read just above
      rdc(8'h32, 8'hee);
      rdc(8'h35, 8'h0c);
      rdc(8'h37, 8'h0e);
      rdc(8'h32, 8'h00);
      // fifo fills until refused, then drains; empty commit changes no status flag
      sample_i.axis_done = 3'h0;
      sample_valid_i = 1'b1;
      k = 0;
      for (n = 0; n < 12; n++) begin
         if (sample_ready_o === 1'b1) k++;
         cyc(1);
      end
      sample_valid_i = 1'b0;
      chk(k[7:0], 8'h08);
      chk({7'h00, sample_ready_o}, 8'h00);
      meas_cycle_end_i = 1'b1;
      cyc(9);
      meas_cycle_end_i = 1'b0;
      cyc(1);
      chk({7'h00, sample_ready_o}, 8'h01);
      rdc(8'h32, 8'h00);
      // two-sample window averages the accel values
      mag_oversample_ratio_i = 3'h1;
      acc(14'h0010, 14'h0010, 14'h3ff0);
      acc(14'h0030, 14'h0030, 14'h3fd0);
      put(3'h7, 16'h0102, 16'h0304, 16'h0506);
      rdc(8'h39, 8'h00);
      rdc(8'h3a, 8'h20);
      rdc(8'h3d, 8'h3f);
      rdc(8'h3e, 8'he0);
      // rate select not below the ratio gives a one-sample window
      output_rate_select_i = 3'h1;
      acc(14'h0005, 14'h0006, 14'h0007);
      put(3'h7, 16'h0000, 16'h0000, 16'h0000);
      rdc(8'h3a, 8'h05);
      rdc(8'h3e, 8'h07);
      // second reset in mid-run
      rst_b_i = 1'b0;
      cyc(2);
      rst_b_i = 1'b1;
      rdc(8'h32, 8'h00);
      rdc(8'h33, 8'h00);
      stop_test;
   end
endmodule
